// [sar_ctrl_pkg.sv]
// Package with register map, field positions, modes and timing counts for the SAR control
package sar_ctrl_pkg;

    // ************************************************************
    // Clock and timing
    // ************************************************************
    localparam int CLK_MHZ        = 250;
    localparam int ACQ_NS         = 250;
    localparam int WAKE_NS        = 100;
    localparam int CONV_FAST_NS   = 700;
    localparam int CONV_NORMAL_NS = 900;
    localparam int CONV_LOWPWR_NS = 1100;
    localparam int IDLE_LIMIT_NS  = 1000000;
    localparam int NBITS          = 14;

    // Least times round up
    localparam int ACQ_CYC  = (ACQ_NS * CLK_MHZ + 999) / 1000;
    localparam int WAKE_CYC = (WAKE_NS * CLK_MHZ + 999) / 1000;
    // Per-bit step times round down to fit the conversion window
    localparam int BIT_CYC_FAST   = (CONV_FAST_NS * CLK_MHZ / 1000) / NBITS;
    localparam int BIT_CYC_NORMAL = (CONV_NORMAL_NS * CLK_MHZ / 1000) / NBITS;
    localparam int BIT_CYC_LOWPWR = (CONV_LOWPWR_NS * CLK_MHZ / 1000) / NBITS;
    localparam int IDLE_LIMIT_CYC = IDLE_LIMIT_NS / 1000 * CLK_MHZ;

    // ************************************************************
    // Codes
    // ************************************************************
    localparam logic [13:0] CODE_MSB   = 14'h2000;
    localparam logic [13:0] CODE_MAX   = 14'h3FFF;
    localparam logic [13:0] CODE_ZERO  = 14'h0000;

    // ************************************************************
    // APB register map
    // ************************************************************
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_RESULT = 8'h08;

    // CTRL fields
    localparam int CTRL_SW_CFG  = 0;
    localparam int CTRL_FAST    = 1;
    localparam int CTRL_LOWPWR  = 2;
    localparam int CTRL_TWOS    = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;

    // STATUS fields
    localparam int STAT_BUSY    = 0;
    localparam int STAT_MODE_LO = 1;
    localparam int STAT_MODE_HI = 2;
    localparam int STAT_TWOS    = 3;
    localparam int STAT_STALE   = 4;
    localparam int STAT_ACQ_OK  = 5;
    localparam int STAT_PDOWN   = 6;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_FAST   = 2'b01,
        MODE_LOWPWR = 2'b10
    } mode_type;

    typedef enum logic [1:0] {
        ST_ACQ  = 2'b00,
        ST_WAKE = 2'b01,
        ST_CONV = 2'b10,
        ST_DONE = 2'b11
    } state_type;

    // Mode from the two selects
    function automatic mode_type mode_decode(input logic fast, input logic lowpwr);
        mode_type m;
        m = MODE_NORMAL;
        if (fast && !lowpwr) begin
            m = MODE_FAST;
        end else if (!fast && lowpwr) begin
            m = MODE_LOWPWR;
        end
        return m;
    endfunction

    // Bit step length for a mode
    function automatic logic [7:0] bit_cycles(input mode_type m);
        logic [7:0] c;
        c = 8'(BIT_CYC_NORMAL);
        case (m)
            MODE_FAST:   c = 8'(BIT_CYC_FAST);
            MODE_LOWPWR: c = 8'(BIT_CYC_LOWPWR);
            default:     c = 8'(BIT_CYC_NORMAL);
        endcase
        return c;
    endfunction

endpackage

// [sar_code_format.sv]
// Output code formatter: straight binary or twos complement with clamping
`timescale 1ns/1ps
module sar_code_format
    import sar_ctrl_pkg::*;
(
    // Raw SAR code and coding select
    input  wire logic [13:0] i_raw,
    input  wire logic        i_twos,
    // Formatted code
    output logic      [13:0] o_code
);

    logic [13:0] clamped;

    always_comb begin
        // Decision loop cannot leave the code range; clamp kept as a guard
        clamped = (i_raw > CODE_MAX) ? CODE_MAX : i_raw;
        // Twos complement is straight binary with the top bit inverted
        o_code  = i_twos ? (clamped ^ CODE_MSB) : clamped;
    end

endmodule // sar_code_format

// [sar_conversion_mode_control.sv]
// SAR conversion sequencer with mode selection and APB configuration
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ps
module sar_conversion_mode_control
    import sar_ctrl_pkg::*;
#(
    parameter int P_IDLE_LIMIT_CYC = IDLE_LIMIT_CYC
)(
    // Clock and reset
    input  wire logic        I_CLK,
    input  wire logic        I_RSTN,
    // Host pins
    input  wire logic        I_CONVERT_START_N,
    input  wire logic        I_FAST_SEL,
    input  wire logic        I_LOWPWR_SEL,
    input  wire logic        I_OUTPUT_CODING_SEL,
    // Comparator decision, same clock domain
    input  wire logic        I_CMP_KEEP,
    // APB slave
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [7:0]  I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic      [31:0] O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    // Converter outputs
    output logic             O_BUSY,
    output logic             O_TRACK,
    output logic             O_POWER_DOWN,
    output logic      [13:0] O_DAC_CODE,
    output logic      [13:0] O_RESULT,
    output logic      [1:0]  O_MODE
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [2:0][3:0] sync;
        logic [3:0]      pin;
        state_type       state;
        mode_type        mode;
        logic            twos;
        logic [3:0]      ctrl;
        logic [7:0]      acq_cnt;
        logic            acq_ok;
        logic [7:0]      step_cnt;
        logic [3:0]      bit_idx;
        logic [13:0]     trial;
        logic [13:0]     result;
        logic            busy;
        logic            pdown;
        logic [19:0]     idle_cnt;
        logic            stale;
        logic [31:0]     prdata;
    } regs_type;

    localparam int PIN_START = 0;
    localparam int PIN_FAST  = 1;
    localparam int PIN_LOWP  = 2;
    localparam int PIN_CODE  = 3;

    localparam logic [7:0]  ACQ_LAST  = 8'(ACQ_CYC - 1);
    localparam logic [7:0]  WAKE_LAST = 8'(WAKE_CYC - 1);
    localparam logic [19:0] IDLE_LIM  = 20'(P_IDLE_LIMIT_CYC);

    regs_type r_q;
    regs_type r_d;

    logic        start_fall;
    logic        wr_en;
    logic        rd_setup;
    logic        addr_ok;
    mode_type    sel_mode;
    logic        sel_twos;
    logic [7:0]  step_last;
    logic [13:0] code_fmt;
    logic [13:0] final_code;

    // ************************************************************
    // Coding formatter
    // ************************************************************
    sar_code_format u_fmt (
        .i_raw  (r_q.trial),
        .i_twos (r_q.twos),
        .o_code (code_fmt)
    );

    assign final_code = code_fmt;

    // ************************************************************
    // Combinational decode
    // ************************************************************
    always_comb begin
        addr_ok  = (I_PADDR == ADDR_CTRL) || (I_PADDR == ADDR_STATUS)
                || (I_PADDR == ADDR_RESULT);
        wr_en    = I_PSEL && I_PENABLE && I_PWRITE && (I_PADDR == ADDR_CTRL);
        rd_setup = I_PSEL && !I_PENABLE;
        // Filtered start pin falls only once stages two and three agree
        start_fall = r_q.pin[PIN_START] && (r_q.sync[1][PIN_START] == r_q.sync[2][PIN_START])
                  && !r_q.sync[2][PIN_START];
        if (r_q.ctrl[CTRL_SW_CFG]) begin
            // Software configuration: select pins are don't care
            sel_mode = mode_decode(r_q.ctrl[CTRL_FAST], r_q.ctrl[CTRL_LOWPWR]);
            sel_twos = r_q.ctrl[CTRL_TWOS];
        end else begin
            sel_mode = mode_decode(r_q.pin[PIN_FAST], r_q.pin[PIN_LOWP]);
            sel_twos = r_q.pin[PIN_CODE];
        end
        step_last = bit_cycles(r_q.mode) - 8'h01;
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        r_d = r_q;

        // Three-stage pin synchronisers and agreement filter
        r_d.sync[0] = {I_OUTPUT_CODING_SEL, I_LOWPWR_SEL, I_FAST_SEL, I_CONVERT_START_N};
        r_d.sync[1] = r_q.sync[0];
        r_d.sync[2] = r_q.sync[1];
        for (int i = 0; i < 4; i++) begin
            if (r_q.sync[1][i] == r_q.sync[2][i]) begin
                r_d.pin[i] = r_q.sync[2][i];
            end
        end

        // Software config writable at any time, no reset needed
        if (wr_en) begin
            r_d.ctrl = I_PWDATA[3:0];
        end

        // Idle time since last conversion, watched only in fast mode
        if (r_q.state == ST_ACQ && r_q.idle_cnt < IDLE_LIM) begin
            r_d.idle_cnt = r_q.idle_cnt + 20'h00001;
        end

        case (r_q.state)
            ST_ACQ: begin
                if (!r_q.acq_ok) begin
                    if (r_q.acq_cnt == ACQ_LAST) begin
                        r_d.acq_ok = 1'b1;
                        // Configuration latches once a whole acquisition has elapsed
                        r_d.mode   = sel_mode;
                        r_d.twos   = sel_twos;
                    end else begin
                        r_d.acq_cnt = r_q.acq_cnt + 8'h01;
                    end
                end else begin
                    // Later config changes still wait one full acquisition
                    if (sel_mode != r_q.mode || sel_twos != r_q.twos) begin
                        r_d.acq_ok  = 1'b0;
                        r_d.acq_cnt = 8'h00;
                    end
                end
                // Edge before acquisition completes is ignored
                if (start_fall && r_q.acq_ok) begin
                    r_d.busy     = 1'b1;
                    r_d.acq_ok   = 1'b0;
                    r_d.acq_cnt  = 8'h00;
                    r_d.step_cnt = 8'h00;
                    r_d.stale    = (r_q.mode == MODE_FAST) && (r_q.idle_cnt >= IDLE_LIM);
                    // MSB trial shown from the start edge, also while waking
                    r_d.bit_idx  = 4'(NBITS - 1);
                    r_d.trial    = CODE_MSB;
                    if (r_q.pdown) begin
                        r_d.state = ST_WAKE;
                    end else begin
                        r_d.state = ST_CONV;
                    end
                end
            end
            ST_WAKE: begin
                if (r_q.step_cnt == WAKE_LAST) begin
                    r_d.pdown    = 1'b0;
                    r_d.step_cnt = 8'h00;
                    r_d.state    = ST_CONV;
                    r_d.bit_idx  = 4'(NBITS - 1);
                    r_d.trial    = CODE_MSB;
                end else begin
                    r_d.step_cnt = r_q.step_cnt + 8'h01;
                end
            end
            ST_CONV: begin
                if (r_q.step_cnt == step_last) begin
                    r_d.step_cnt = 8'h00;
                    // Drop trial bit when comparator says too high
                    if (!I_CMP_KEEP) begin
                        r_d.trial[r_q.bit_idx] = 1'b0;
                    end
                    if (r_q.bit_idx == 4'h0) begin
                        r_d.state = ST_DONE;
                    end else begin
                        // Halve the step: next lower bit on trial
                        r_d.bit_idx = r_q.bit_idx - 4'h1;
                        r_d.trial[r_q.bit_idx - 4'h1] = 1'b1;
                    end
                end else begin
                    r_d.step_cnt = r_q.step_cnt + 8'h01;
                end
            end
            ST_DONE: begin
                r_d.result   = final_code;
                r_d.busy     = 1'b0;
                r_d.pdown    = (r_q.mode == MODE_LOWPWR);
                r_d.idle_cnt = 20'h00000;
                r_d.state    = ST_ACQ;
            end
            default: begin
                r_d.state = ST_ACQ;
                r_d.busy  = 1'b0;
            end
        endcase

        // APB read data captured in the setup cycle
        if (rd_setup) begin
            r_d.prdata = 32'h00000000;
            case (I_PADDR)
                ADDR_CTRL: begin
                    r_d.prdata[3:0] = r_q.ctrl;
                end
                ADDR_STATUS: begin
                    r_d.prdata[STAT_BUSY]                 = r_q.busy;
                    r_d.prdata[STAT_MODE_HI:STAT_MODE_LO] = r_q.mode;
                    r_d.prdata[STAT_TWOS]                 = r_q.twos;
                    r_d.prdata[STAT_STALE]                = r_q.stale;
                    r_d.prdata[STAT_ACQ_OK]               = r_q.acq_ok;
                    r_d.prdata[STAT_PDOWN]                = r_q.pdown;
                end
                ADDR_RESULT: begin
                    r_d.prdata[13:0] = r_q.result;
                end
                default: begin
                    r_d.prdata = 32'h00000000;
                end
            endcase
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            r_q <= '{
                sync:     12'h111,
                pin:      4'h1,
                state:    ST_ACQ,
                mode:     MODE_NORMAL,
                twos:     1'b0,
                ctrl:     CTRL_RESET,
                acq_cnt:  8'h00,
                acq_ok:   1'b0,
                step_cnt: 8'h00,
                bit_idx:  4'h0,
                trial:    CODE_ZERO,
                result:   CODE_ZERO,
                busy:     1'b0,
                pdown:    1'b0,
                idle_cnt: 20'h00000,
                stale:    1'b0,
                prdata:   32'h00000000
            };
        end else begin
            r_q <= r_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign O_PRDATA     = r_q.prdata;
    assign O_PREADY     = 1'b1;
    assign O_PSLVERR    = I_PSEL && I_PENABLE && !addr_ok;
    assign O_BUSY       = r_q.busy;
    assign O_TRACK      = (r_q.state == ST_ACQ);
    assign O_POWER_DOWN = r_q.pdown;
    assign O_DAC_CODE   = r_q.trial;
    assign O_RESULT     = r_q.result;
    assign O_MODE       = r_q.mode;

endmodule // sar_conversion_mode_control

// [sar_conversion_mode_control_assertions.sv]
// Concurrent checks on the ports of the SAR conversion sequencer
`timescale 1ns/1ps
module sar_conversion_mode_control_assertions
    import sar_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic        I_CLK,
    input  wire logic        I_RSTN,
    // Converter outputs
    input  wire logic        O_BUSY,
    input  wire logic        O_TRACK,
    input  wire logic        O_POWER_DOWN,
    input  wire logic [13:0] O_DAC_CODE,
    input  wire logic [13:0] O_RESULT,
    input  wire logic [1:0]  O_MODE
);
    default clocking dcb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RSTN);

    localparam int WMAX = WAKE_CYC + 3;
    int bcnt;
    int tcnt;
    int minl;

    // ************
    // Busy and acquisition lengths
    // ************
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            bcnt <= 0;
            tcnt <= 0;
        end else begin
            bcnt <= O_BUSY ? bcnt + 1 : 0;
            tcnt <= O_TRACK ? tcnt + 1 : 0;
        end
    end
    always_comb begin
        minl = NBITS * (O_MODE == MODE_FAST ? BIT_CYC_FAST :
                        O_MODE == MODE_LOWPWR ? BIT_CYC_LOWPWR : BIT_CYC_NORMAL);
    end

    // ************
    // Properties
    // ************
    msb_first_a: assert property ($rose(O_BUSY) |-> O_DAC_CODE == CODE_MSB && !O_TRACK)
        else $error("trial code not at msb when busy rises");
    track_busy_a: assert property (O_BUSY |-> !O_TRACK)
        else $error("tracking while busy");
    acq_done_a: assert property ($rose(O_BUSY) |-> tcnt >= ACQ_CYC - 1)
        else $error("conversion before acquisition ended");
    dac_step_a: assert property (O_BUSY && $past(O_BUSY) && $changed(O_DAC_CODE)
        |-> $countones(O_DAC_CODE ^ $past(O_DAC_CODE)) <= 2)
        else $error("trial code step not binary");
    conv_len_a: assert property ($fell(O_BUSY) |-> bcnt >= minl &&
        bcnt <= minl + WAKE_CYC + 4)
        else $error("conversion length wrong for mode");
    pdown_after_a: assert property ($fell(O_BUSY) && O_MODE == MODE_LOWPWR |-> O_POWER_DOWN)
        else $error("low power mode not powered down");
    wake_up_a: assert property ($rose(O_BUSY) |-> ##[0:WMAX] !O_POWER_DOWN)
        else $error("circuits not restored");
    result_hold_a: assert property ($changed(O_RESULT) |-> $fell(O_BUSY))
        else $error("result changed outside completion");
    mode_hold_a: assert property (O_BUSY && $past(O_BUSY) |-> $stable(O_MODE))
        else $error("mode changed during conversion");
endmodule // sar_conversion_mode_control_assertions

bind sar_conversion_mode_control sar_conversion_mode_control_assertions chk_u (
    .I_CLK(I_CLK), .I_RSTN(I_RSTN), .O_BUSY(O_BUSY), .O_TRACK(O_TRACK),
    .O_POWER_DOWN(O_POWER_DOWN), .O_DAC_CODE(O_DAC_CODE), .O_RESULT(O_RESULT),
    .O_MODE(O_MODE)
);

// [sar_host_model.sv]
// Model of the host start strobe and the analog comparator
`timescale 1ns/1ps
module sar_host_model (
    // Clock, reset and bench control
    input  wire logic               i_clk,
    input  wire logic               i_rstn,
    input  wire logic               i_go,
    input  wire logic signed [31:0] i_vin,
    // Converter side
    output logic                    o_start_n,
    output logic                    o_keep,
    input  wire logic        [13:0] i_dac
);
    int   low_cnt = 0;
    logic st_q    = 1'h1;
    logic keep_q  = 1'h0;

    // ************
    // Strobe held low long enough for the pin filter
    // ************
    always @(posedge i_clk) begin
        if (i_go) begin
            low_cnt <= 8;
        end else if (low_cnt > 0) begin
            low_cnt <= low_cnt - 1;
        end
        st_q   <= !(i_go || low_cnt > 1);
        keep_q <= $signed({18'h0, i_dac}) <= i_vin;
    end
    assign o_start_n = st_q | !i_rstn;
    assign o_keep    = keep_q & i_rstn;
endmodule // sar_host_model

// [tb_sar_conversion_mode_control.sv]
// Self-checking bench for the SAR conversion mode control
`timescale 1ns/1ps
module tb_sar_conversion_mode_control;
    import sar_ctrl_pkg::*;
    localparam int IDLE = 200;
    logic               clk    = 1'h0;
    logic               rstn   = 1'h0;
    logic               fs     = 1'h0;
    logic               lp     = 1'h0;
    logic               oc     = 1'h0;
    logic               go     = 1'h0;
    logic               psel   = 1'h0;
    logic               pen    = 1'h0;
    logic               pwr    = 1'h0;
    logic [7:0]         paddr  = 8'h00;
    logic [31:0]        pwdata = 32'h0;
    logic signed [31:0] vin    = 32'h0;
    logic [31:0]        prdata, r;
    logic               pready, pslverr, busy, track, pdown, e, keep, start_n;
    logic [13:0]        dac, res;
    logic [1:0]         mode;
    int                 error_cnt = 0, tests_run = 0, cyc = 0, last;
    int                 q[$];
    int                 cv[4] = '{8192, 8193, 20000, -100};

    sar_conversion_mode_control #(.P_IDLE_LIMIT_CYC(IDLE)) dut_u (
        .I_CLK(clk), .I_RSTN(rstn), .I_CONVERT_START_N(start_n), .I_FAST_SEL(fs),
        .I_LOWPWR_SEL(lp), .I_OUTPUT_CODING_SEL(oc), .I_CMP_KEEP(keep), .I_PSEL(psel),
        .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .O_BUSY(busy),
        .O_TRACK(track), .O_POWER_DOWN(pdown), .O_DAC_CODE(dac), .O_RESULT(res),
        .O_MODE(mode));
    sar_host_model host_u (.i_clk(clk), .i_rstn(rstn), .i_go(go), .i_vin(vin),
        .o_start_n(start_n), .o_keep(keep), .i_dac(dac));

    // ************
    // Clock, timeout and helpers
    // ************
    initial begin
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            $display("CHECK FAILED %0t timeout", $time);
            final_report();
        end
    end
    task automatic final_report;
        if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t %s got %0h exp %0h", $time, m, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'h1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'h1;
        do begin
            @(posedge clk);
        end while (pready !== 1'h1);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        pen  <= 1'h0;
    endtask
    // One conversion, with a refused start pulse while busy
    task automatic conv(input int v, input logic [1:0] m, input logic tw);
        int n;
        int b;
        n = (v < 0) ? 0 : (v > 16383) ? 16383 : v;
        last = tw ? n ^ 8192 : n;
        q.push_back(last);
        b = (m == MODE_FAST) ? BIT_CYC_FAST : (m == MODE_LOWPWR) ? BIT_CYC_LOWPWR : BIT_CYC_NORMAL;
        vin <= v;
        repeat (80) @(posedge clk);
        go <= 1'h1;
        @(posedge clk);
        go <= 1'h0;
        n = 0;
        while (busy !== 1'h1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        cmp(dac, 32'h2000, "trial msb");
        n = 0;
        while (busy !== 1'h0 && n < 400) begin
            @(negedge clk);
            n++;
            go <= (n == 20);
        end
        cmp(n >= 14 * b && n <= 14 * b + 30, 32'h1, "busy length");
        cmp(res, q.pop_front(), "result");
        cmp(mode, m, "mode");
    endtask

    // ************
    // Main sequence
    // ************
    initial begin
        logic [1:0] m;
        void'($urandom(32'h39DD));
        repeat (16) @(posedge clk);
        rstn <= 1'h1;
        @(negedge clk);
        cmp({busy, track, pdown, mode, res}, 32'h20000, "reset outputs");
        apb(1'h0, ADDR_CTRL, 32'h0);
        cmp(r, 32'h0, "ctrl reset");
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            fs <= i[0];
            lp <= i[1];
            m = (i == 1) ? MODE_FAST : (i == 2) ? MODE_LOWPWR : MODE_NORMAL;
            repeat (2) conv($urandom_range(16383), m, 1'h0);
            if (i == 2) cmp(pdown, 32'h1, "power down");
        end
        for (int t = 0; t < 2; t++) begin
            @(posedge clk);
            oc <= t[0];
            foreach (cv[k]) conv(cv[k], MODE_NORMAL, t[0]);
        end
        @(posedge clk);
        fs <= 1'h0;
        apb(1'h1, ADDR_CTRL, 32'h3);
        conv($urandom_range(16383), MODE_FAST, 1'h0);
        apb(1'h0, ADDR_CTRL, 32'h0);
        cmp(r, 32'h3, "ctrl readback");
        apb(1'h0, ADDR_RESULT, 32'h0);
        cmp(r, last, "result register");
        apb(1'h0, ADDR_STATUS, 32'h0);
        cmp(r[2:1], 32'h1, "status mode");
        apb(1'h1, ADDR_CTRL, 32'hD);
        conv($urandom_range(16383), MODE_LOWPWR, 1'h1);
        apb(1'h1, ADDR_CTRL, 32'h3);
        repeat (IDLE + 100) @(posedge clk);
        conv($urandom_range(16383), MODE_FAST, 1'h0);
        apb(1'h0, ADDR_STATUS, 32'h0);
        cmp(r[4], 32'h1, "stale flag");
        apb(1'h1, ADDR_CTRL, 32'h1);
        repeat (IDLE + 100) @(posedge clk);
        conv($urandom_range(16383), MODE_NORMAL, 1'h0);
        apb(1'h0, ADDR_STATUS, 32'h0);
        cmp(r[4], 32'h0, "normal no stale");
        apb(1'h0, 8'h0C, 32'h0);
        cmp(e, 32'h1, "unmapped error");
        cmp(r, 32'h0, "unmapped data");
        apb(1'h1, ADDR_STATUS, 32'hFFFFFFFF);
        apb(1'h0, ADDR_CTRL, 32'h0);
        cmp(r, 32'h1, "ctrl kept");
        final_report();
    end
endmodule // tb_sar_conversion_mode_control
